// [include/psd_pkg.sv]
// Shared constants and types for the processor slice datapath
package psd_pkg;
    localparam int DATA_W   = 4;
    localparam int ADDR_W   = 4;
    localparam int WORDS    = 16;
    localparam int INSTR_W  = 8;
    localparam int CTRL_W   = 17;
    localparam int DECODE_BITS = 352;

    // Operand conditioning codes
    localparam logic [1:0] COND_ZERO = 2'h0;
    localparam logic [1:0] COND_ONE  = 2'h1;
    localparam logic [1:0] COND_TRUE = 2'h2;
    localparam logic [1:0] COND_COMP = 2'h3;

    // Output select codes
    localparam logic [1:0] OSEL_ALU = 2'h0;
    localparam logic [1:0] OSEL_A   = 2'h1;
    localparam logic [1:0] OSEL_B   = 2'h2;

    // Shift codes, shared by both shifters
    localparam logic [1:0] SH_NONE  = 2'h0;
    localparam logic [1:0] SH_LEFT  = 2'h1;
    localparam logic [1:0] SH_RIGHT = 2'h2;

    // ALU function codes
    localparam logic [1:0] FN_ADD = 2'h0;
    localparam logic [1:0] FN_AND = 2'h1;
    localparam logic [1:0] FN_OR  = 2'h2;
    localparam logic [1:0] FN_XOR = 2'h3;

    // Control word: 17 lines
    typedef struct packed {
        logic       asel_din;  // 1: data in, 0: A latch
        logic       bsel_ext;  // 1: extension reg, 0: B latch
        logic [1:0] acond;
        logic [1:0] bcond;
        logic [1:0] fn;
        logic [1:0] osel;
        logic [1:0] shift;
        logic       acc_we;
        logic       ext_load;
        logic       ext_shift;
        logic [1:0] spare;
    } psd_ctrl_t;

    localparam logic [DATA_W-1:0] ZERO_NIB = 4'h0;
    localparam logic [DATA_W-1:0] ONES_NIB = 4'hF;
endpackage

// [include/psd_ctrl_if.sv]
`timescale 1ns/1ps
// Decoded control bundle between decoder and datapath
interface psd_ctrl_if;
    import psd_pkg::*;
    logic [psd_pkg::INSTR_W-1:0] instr;
    psd_ctrl_t                   ctrl;
    modport dec (input instr, output ctrl);
    modport dp  (output instr, input ctrl);
endinterface

// [logic/psd_decode.sv]
`timescale 1ns/1ps
// Instruction decoder: constant lookup table to control lines
module psd_decode
    import psd_pkg::*;
(
    psd_ctrl_if.dec cif
);
    // Table function built from instruction fields
    function automatic psd_ctrl_t decode(input logic [INSTR_W-1:0] i);
        psd_ctrl_t c;
        c = '0;
        c.asel_din  = i[7];
        c.bsel_ext  = i[6];
        c.fn        = i[5:4];
        c.shift     = (i[1:0] == 2'h3) ? SH_NONE : i[1:0];
        c.osel      = (i[3:2] == 2'h3) ? OSEL_ALU : i[3:2];
        c.acond     = COND_TRUE;
        c.bcond     = COND_TRUE;
        if (i[5:4] == FN_ADD && i[3:2] == 2'h3) begin
            c.acond = i[1] ? COND_COMP : COND_TRUE;
            c.bcond = i[0] ? COND_COMP : COND_TRUE;
            c.shift = SH_NONE;
        end
        // Forced constants: B is zero or all ones, A may be zeroed
        if (i[5:4] == FN_OR && i[3:2] == 2'h3) begin
            c.acond = (i[1:0] == 2'h2) ? COND_ZERO : COND_TRUE;
            c.bcond = i[0] ? COND_ZERO : COND_ONE;
            c.shift = SH_NONE;
        end
        c.acc_we    = i[2] ^ i[3] ? 1'b0 : 1'b1;
        c.ext_load  = i[6] ? 1'b0 : i[0] & i[1];
        c.ext_shift = i[6] & (i[1:0] != 2'h0) & (i[1:0] != 2'h3);
        return c;
    endfunction

    assign cif.ctrl = decode(cif.instr);
endmodule

// [logic/psd_slice.sv]
`timescale 1ns/1ps
// Four-bit cascadable processor slice datapath
// Functional notes
// - Eight instruction lines decode through lookup tables into 17 controls.
// - Sixteen by four accumulator file read through independent A and B ports.
// - A port is read only; writes go to the B address.
// - Enabled writes happen in the clock low phase.
// - Clock held high computes results but stores nothing.
// - Port latches follow while clock high, hold from the falling edge.
// - First operand from data in or A latch; second from B or extension.
// - B operand passes as zero, all ones, true or complement; A operand as zero, true or complement.
// - Overflow flag plus high-true zero and low-true all-ones indications.
// - Data output chooses ALU result, A latch or B latch.
// - Data outputs driven only while output enable low.
// - Extension register loads the result or shifts one place.
// - Result stored unshifted or shifted one bit left or right.
// - Both shifters use bidirectional end pins joined across slices.
// - Carry look-ahead generate and propagate outputs allow cascading.
// - Extension register stores on low phase, commits at the rising edge.
// - Extension and accumulator shifts share direction controls.
module psd_slice
    import psd_pkg::*;
#(
    parameter int W = DATA_W
) (
    input  wire logic              mclk,
    input  wire logic              rstn,
    input  wire logic              phase_clk,
    input  wire logic [INSTR_W-1:0] instr,
    input  wire logic [ADDR_W-1:0] addr_a,
    input  wire logic [ADDR_W-1:0] addr_b,
    input  wire logic [W-1:0]      data_in,
    input  wire logic              carry_in,
    input  wire logic              oe_n,
    output logic [W-1:0]           data_out,
    output logic                   data_out_oe,
    output logic                   carry_out,
    output logic                   gen_n,
    output logic                   prop_n,
    output logic                   overflow,
    output logic                   zero_hi,
    output logic                   ones_n,
    input  wire logic              acc_lo_i,
    output logic                   acc_lo_o,
    output logic                   acc_lo_oe,
    input  wire logic              acc_hi_i,
    output logic                   acc_hi_o,
    output logic                   acc_hi_oe,
    input  wire logic              ext_lo_i,
    output logic                   ext_lo_o,
    output logic                   ext_lo_oe,
    input  wire logic              ext_hi_i,
    output logic                   ext_hi_o,
    output logic                   ext_hi_oe
);
    typedef struct packed {
        logic [1:0]   phs_sync;
        logic         phase_d;
        logic [6:0]   pin_sync1;
        logic [6:0]   pin_sync2;
        logic [W-1:0] lat_a;
        logic [W-1:0] lat_b;
        logic [W-1:0] ext_master;
        logic [W-1:0] ext;
        logic [W-1:0] dout;
        logic         ovf;
        logic         cout;
        logic         g_n;
        logic         p_n;
        logic         zh;
        logic         on;
    } psd_state_t;

    psd_state_t st_reg;
    psd_state_t st_next;
    logic [W-1:0] acc_mem [WORDS];
    logic [W-1:0] acc_wdata;
    logic         acc_wr;

    psd_ctrl_if cif ();
    assign cif.instr = instr;
    psd_decode u_dec (.cif(cif));

    function automatic logic [W-1:0] cond_op(input logic [1:0] c, input logic [W-1:0] v);
        case (c)
            COND_ZERO: cond_op = '0;
            COND_ONE:  cond_op = '1;
            COND_TRUE: cond_op = v;
            default:   cond_op = ~v;
        endcase
    endfunction

    psd_ctrl_t    c;
    logic         clk_hi;
    logic         fall;
    logic [W-1:0] op_a;
    logic [W-1:0] op_b;
    logic [W-1:0] f;
    logic [W:0]   sum;
    logic [W-1:0] ext_d;
    logic         cin_s;

    assign c      = cif.ctrl;
    assign clk_hi = st_reg.phs_sync[1];
    assign fall   = st_reg.phase_d & ~clk_hi;
    assign cin_s  = st_reg.pin_sync2[0];

    always_comb begin
        st_next = st_reg;
        st_next.phs_sync  = {st_reg.phs_sync[0], phase_clk};
        st_next.phase_d   = clk_hi;
        st_next.pin_sync1 = {acc_lo_i, acc_hi_i, ext_lo_i, ext_hi_i, 2'b00, carry_in};
        st_next.pin_sync2 = st_reg.pin_sync1;
        // Latches transparent while clock high
        if (clk_hi) begin
            st_next.lat_a = acc_mem[addr_a];
            st_next.lat_b = acc_mem[addr_b];
        end
        op_a = cond_op(c.acond, c.asel_din ? data_in : st_reg.lat_a);
        op_b = cond_op(c.bcond, c.bsel_ext ? st_reg.ext : st_reg.lat_b);
        sum  = {1'b0, op_a} + {1'b0, op_b} + {{W{1'b0}}, cin_s};
        case (c.fn)
            FN_ADD:  f = sum[W-1:0];
            FN_AND:  f = op_a & op_b;
            FN_OR:   f = op_a | op_b;
            default: f = op_a ^ op_b;
        endcase
        st_next.cout = sum[W];
        st_next.g_n  = ~sum[W];
        st_next.p_n  = ~(&(op_a | op_b));
        st_next.ovf  = (c.fn == FN_ADD) & (op_a[W-1] == op_b[W-1]) & (f[W-1] != op_a[W-1]);
        st_next.zh   = (f == '0);
        st_next.on   = ~(f == '1);
        case (c.osel)
            OSEL_A:  st_next.dout = st_reg.lat_a;
            OSEL_B:  st_next.dout = st_reg.lat_b;
            default: st_next.dout = f;
        endcase
        // Extension master loads in low phase; shift controls shared
        case (c.shift)
            SH_LEFT:  ext_d = {st_reg.ext[W-2:0], st_reg.pin_sync2[4]};
            SH_RIGHT: ext_d = {st_reg.pin_sync2[3], st_reg.ext[W-1:1]};
            default:  ext_d = st_reg.ext;
        endcase
        if (!clk_hi && c.ext_load) begin
            st_next.ext_master = f;
        end else if (!clk_hi && c.ext_shift) begin
            st_next.ext_master = ext_d;
        end
        if (clk_hi && !st_reg.phase_d) begin
            st_next.ext = st_reg.ext_master;
        end
        if (clk_hi) begin
            st_next.ext_master = st_next.ext;
        end
    end

    // Accumulator write data after shifter
    always_comb begin
        case (c.shift)
            SH_LEFT:  acc_wdata = {f[W-2:0], st_reg.pin_sync2[6]};
            SH_RIGHT: acc_wdata = {st_reg.pin_sync2[5], f[W-1:1]};
            default:  acc_wdata = f;
        endcase
        acc_wr = c.acc_we & fall;
    end

    always_ff @(posedge mclk) begin
        if (acc_wr) begin
            acc_mem[addr_b] <= acc_wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign data_out    = st_reg.dout;
    assign data_out_oe = ~oe_n;
    assign carry_out   = st_reg.cout;
    assign gen_n       = st_reg.g_n;
    assign prop_n      = st_reg.p_n;
    assign overflow    = st_reg.ovf;
    assign zero_hi     = st_reg.zh;
    assign ones_n      = st_reg.on;
    // End pins drive out in shift direction
    assign acc_lo_o    = f[0];
    assign acc_lo_oe   = (c.shift == SH_RIGHT);
    assign acc_hi_o    = f[W-1];
    assign acc_hi_oe   = (c.shift == SH_LEFT);
    assign ext_lo_o    = st_reg.ext[0];
    assign ext_lo_oe   = (c.shift == SH_RIGHT) & c.ext_shift;
    assign ext_hi_o    = st_reg.ext[W-1];
    assign ext_hi_oe   = (c.shift == SH_LEFT) & c.ext_shift;

    a_oe_follow: assert property (@(posedge mclk) disable iff (!rstn) data_out_oe == !oe_n)
        else $error("output enable mismatch");
    a_zero_flag: assert property (@(posedge mclk) disable iff (!rstn)
        (f == '0) |=> zero_hi)
        else $error("zero flag missing");
    a_no_write_hi: assert property (@(posedge mclk) disable iff (!rstn) clk_hi |-> !acc_wr)
        else $error("write while clock high");
    a_ext_hold: assert property (@(posedge mclk) disable iff (!rstn)
        (clk_hi && st_reg.phase_d) |=> $stable(st_reg.ext))
        else $error("extension changed while high");
    a_lat_hold: assert property (@(posedge mclk) disable iff (!rstn)
        !clk_hi |=> $stable(st_reg.lat_a))
        else $error("latch not holding");
    a_out_sel_a: assert property (@(posedge mclk) disable iff (!rstn)
        (c.osel == OSEL_A) |=> data_out == $past(st_reg.lat_a))
        else $error("output select wrong");
    a_ones_flag: assert property (@(posedge mclk) disable iff (!rstn)
        (f == '1) |=> !ones_n)
        else $error("ones flag wrong");
    a_shift_pins: assert property (@(posedge mclk) disable iff (!rstn)
        !(acc_lo_oe && acc_hi_oe))
        else $error("both shift ends driven");
endmodule

// [dv/psd_ctrl_model.sv]
// Controller and neighbour slice model: phase clock and shift end pins
`timescale 1ns/1ps
module psd_ctrl_model (
    input  wire logic       mclk,
    input  wire logic       phase_hold,
    output logic            phase_clk,
    input  wire logic [3:0] oe,
    input  wire logic [3:0] dout,
    output logic [3:0]      din
);
    logic [1:0] cnt = 2'h0;
    logic [3:0] nb  = 4'h5;
    logic       ph  = 1'b1;
    always @(posedge mclk) begin
        nb <= ~nb ^ {3'h0, nb[3]};
        cnt <= cnt + 2'h1;
        if (phase_hold) begin
            ph <= 1'b1;
        end else if (cnt == 2'h3) begin
            ph <= ~ph;
        end
    end
    assign phase_clk = ph;
    // Released ends show a changing pattern, never the last value
    assign din = (oe & dout) | (~oe & nb);
endmodule

// [dv/psd_slice_tb.sv]
// Self-checking bench for the processor slice datapath
`timescale 1ns/1ps
module psd_slice_tb;
    import psd_pkg::*;
    logic       mclk, rstn, phase_hold, phase_clk, carry_in, oe_n;
    logic [7:0] instr;
    logic [3:0] addr_a, addr_b, data_in, data_out, sh_oe, sh_o, sh_i;
    logic       data_out_oe, carry_out, gen_n, prop_n, overflow, zero_hi, ones_n;
    int         n_errors, samples_checked;

    psd_ctrl_model i_ctrl (.mclk(mclk), .phase_hold(phase_hold), .phase_clk(phase_clk),
        .oe(sh_oe), .dout(sh_o), .din(sh_i));
    psd_slice i_dut (.mclk(mclk), .rstn(rstn), .phase_clk(phase_clk), .instr(instr),
        .addr_a(addr_a), .addr_b(addr_b), .data_in(data_in), .carry_in(carry_in),
        .oe_n(oe_n), .data_out(data_out), .data_out_oe(data_out_oe),
        .carry_out(carry_out), .gen_n(gen_n), .prop_n(prop_n), .overflow(overflow),
        .zero_hi(zero_hi), .ones_n(ones_n),
        .acc_lo_i(sh_i[0]), .acc_lo_o(sh_o[0]), .acc_lo_oe(sh_oe[0]),
        .acc_hi_i(sh_i[1]), .acc_hi_o(sh_o[1]), .acc_hi_oe(sh_oe[1]),
        .ext_lo_i(sh_i[2]), .ext_lo_o(sh_o[2]), .ext_lo_oe(sh_oe[2]),
        .ext_hi_i(sh_i[3]), .ext_hi_o(sh_o[3]), .ext_hi_oe(sh_oe[3]));

    always #2 mclk = ~mclk;

    function automatic logic [7:0] mk(logic a, logic [1:0] fn, logic [1:0] os, logic [1:0] sh);
        return {a, 1'b0, fn, os, sh};
    endfunction

    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check_bit(string what, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic check_nib(string what, logic [3:0] exp, logic [3:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic settle(int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic put(logic [7:0] i, logic [3:0] d);
        @(posedge mclk);
        instr <= i;
        data_in <= d;
    endtask

    task automatic test_oe();
        for (int k = 1; k >= 0; k--) begin
            @(posedge mclk);
            oe_n <= k[0];
            settle(1);
            check_bit("data_out_oe", ~k[0], data_out_oe);
        end
        $display("test oe done");
    endtask

    task automatic test_flags();
        logic [3:0] v [4] = '{4'h0, 4'hF, 4'h5, 4'hA};
        logic [3:0] e;
        // Word 0 holds zero, so B is zero and carry in is clear
        @(posedge mclk);
        addr_b <= 4'h0;
        carry_in <= 1'b0;
        for (int f = 0; f < 4; f++) begin
            for (int k = 0; k < 4; k++) begin
                put(mk(1'b1, f[1:0], OSEL_ALU, SH_NONE), v[k]);
                settle(5);
                e = (f[1:0] == FN_AND) ? 4'h0 : v[k];
                check_nib("alu result", e, data_out);
                check_bit("zero_hi", e == 4'h0, zero_hi);
                check_bit("ones_n", e != 4'hF, ones_n);
            end
        end
        $display("test flags done");
    endtask

    task automatic arith_case(logic [7:0] i, logic [3:0] ab, logic [3:0] d, logic ci,
                              logic [3:0] ef, logic [3:0] ex);
        @(posedge mclk);
        addr_b <= ab;
        carry_in <= ci;
        put(i, d);
        settle(5);
        check_nib("alu result", ef, data_out);
        check_nib("flags", ex, {carry_out, overflow, gen_n, prop_n});
    endtask

    task automatic test_arith();
        logic [7:0] add_i;
        add_i = mk(1'b1, FN_ADD, OSEL_ALU, SH_NONE);
        arith_case(add_i, 4'h3, 4'h5, 1'b0, 4'h8, 4'h7);
        arith_case(add_i, 4'h7, 4'h9, 1'b0, 4'h0, 4'h8);
        arith_case(add_i, 4'h3, 4'h4, 1'b1, 4'h8, 4'h7);
        arith_case(mk(1'b1, FN_ADD, 2'h3, 2'h1), 4'h7, 4'h9, 1'b1, 4'h2, 4'hD);
        arith_case(mk(1'b1, FN_ADD, 2'h3, 2'h2), 4'h7, 4'h9, 1'b1, 4'hE, 4'h7);
        $display("test arith done");
    endtask

    task automatic test_ext();
        @(posedge mclk);
        addr_b <= 4'h8;
        // Pass data in through a zeroed B port and load the extension
        put(mk(1'b1, FN_OR, 2'h3, 2'h3), 4'hA);
        settle(24);
        put(mk(1'b1, FN_OR, OSEL_ALU, SH_NONE) | 8'h40, 4'h0);
        settle(4);
        check_nib("extension via b port", 4'hA, data_out);
        $display("test ext done");
    endtask

    task automatic test_select();
        logic [3:0] va;
        for (int k = 0; k < 15; k += 5) begin
            @(posedge mclk);
            addr_a <= k[3:0];
            addr_b <= 4'(14 - k);
            put(mk(1'b0, FN_ADD, OSEL_A, SH_NONE), 4'h3);
            settle(4);
            va = data_out;
            put(mk(1'b0, FN_ADD, OSEL_B, SH_NONE), 4'h3);
            settle(4);
            check_nib("port a word", k[3:0], va);
            check_nib("port b word", 4'(14 - k), data_out);
        end
        $display("test select done");
    endtask

    task automatic test_hold();
        @(posedge mclk);
        addr_b <= 4'h5;
        for (int k = 0; k < 8; k++) begin
            put(mk(1'b1, k[1:0], OSEL_ALU, k[0] ? SH_LEFT : SH_RIGHT), k[3:0]);
            settle(3);
            put(mk(1'b1, FN_ADD, OSEL_B, SH_NONE), 4'h0);
            settle(3);
            check_nib("held word", 4'h5, data_out);
        end
        $display("test hold done");
    endtask

    task automatic test_shift();
        put(mk(1'b1, FN_ADD, OSEL_ALU, SH_NONE), 4'h6);
        settle(4);
        check_bit("acc ends both driven", 1'b0, sh_oe[0] & sh_oe[1]);
        // Extension shifts only with B taken from the extension
        put(mk(1'b1, FN_ADD, OSEL_ALU, SH_LEFT) | 8'h40, 4'h6);
        settle(4);
        check_nib("left end drives", 4'hA, sh_oe);
        put(mk(1'b1, FN_ADD, OSEL_ALU, SH_RIGHT) | 8'h40, 4'h6);
        settle(4);
        check_nib("right end drives", 4'h5, sh_oe);
        $display("test shift done");
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        complete_run();
    end

    initial begin
        mclk = 1'b0;
        rstn = 1'b0;
        phase_hold = 1'b0;
        carry_in = 1'b0;
        oe_n = 1'b0;
        instr = 8'h00;
        addr_a = 4'h0;
        addr_b = 4'h0;
        data_in = 4'h0;
        n_errors = 0;
        samples_checked = 0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        // Fill words through store phases
        for (int k = 0; k < 16; k++) begin
            @(posedge mclk);
            addr_b <= k[3:0];
            carry_in <= k[0];
            put(mk(1'b1, FN_OR, 2'h3, 2'h1), k[3:0]);
            settle(8);
        end
        test_oe();
        test_shift();
        test_ext();
        @(posedge mclk);
        phase_hold <= 1'b1;
        settle(8);
        test_flags();
        test_arith();
        test_select();
        test_hold();
        complete_run();
    end
endmodule
